//--- hdl/erxpo_pkg.sv
/*
 Package for the receive pattern offset and station address register block.
 Holds register offsets, field positions, reset values and the bus request type.
 Assumes an APB slave with 32-bit data and byte-addressed, word-aligned registers.
*/
// Behaviour
// - Offset field is 16 bits in low half, zero at reset, upper half reads zero.
// - Offset feeds only the receive path, never transmit.
// - Station address bits 15:8 hold the octet sent second.
// - Station address bits 7:0 hold the first sent, most significant octet.
// - 16-bit and 32-bit accesses, incl. set/clear/invert aliases, work, except offset writes while receive is enabled with a nonzero mode; 8-bit ignored.
// - Station address loads from the factory value on the first clock after reset release.
package erxpo_pkg;
   localparam logic [11:0] OFS_MATCH_OFS = 12'h000;
   localparam logic [11:0] OFS_MATCH_OFS_CLR = 12'h004;
   localparam logic [11:0] OFS_MATCH_OFS_SET = 12'h008;
   localparam logic [11:0] OFS_MATCH_OFS_INV = 12'h00C;
   localparam logic [11:0] OFS_SA = 12'h010;
   localparam logic [11:0] OFS_SA_CLR = 12'h014;
   localparam logic [11:0] OFS_SA_SET = 12'h018;
   localparam logic [11:0] OFS_SA_INV = 12'h01C;
   localparam logic [11:0] OFS_CTRL = 12'h020;
   localparam int CTRL_RX_ENABLE_BIT = 0;
   localparam int CTRL_MODE_LSB = 8;
   localparam logic [15:0] MATCH_OFS_RESET = 16'h0000;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [3:0] STRB_HALF_LO = 4'h3;
   localparam logic [3:0] STRB_HALF_HI = 4'hC;
   localparam logic [3:0] STRB_WORD = 4'hF;

   typedef enum {erxpo_op_write, erxpo_op_clr, erxpo_op_set, erxpo_op_inv} erxpo_op_t;

   typedef struct packed {
      logic [11:0] addr;
      logic write;
      logic [31:0] wdata;
      logic [3:0] strb;
   } erxpo_req_t;
endpackage : erxpo_pkg

//--- hdl/erxpo_regs.sv
/*
 Register block: receive pattern match offset and low station address octets.
 Assumes an APB master on clk, and a factory station address stable at reset release.
*/
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module erxpo_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Factory value
   input wire logic [15:0] factory_station_addr,
   // Receive path and transmit path outputs
   output logic [15:0] rx_pattern_match_offset,
   output logic [7:0] station_addr_octet_first,
   output logic [7:0] station_addr_octet_second
);
   erxpo_pkg::erxpo_req_t req;
   logic access;
   logic size_ok;
   logic [15:0] pattern_match_offset;
   logic [15:0] station_addr;
   logic [31:0] control;
   logic sa_loaded;
   logic receive_enable_bit;
   logic [3:0] pattern_match_mode_select;
   logic match_ofs_locked;
   logic [15:0] next_match_ofs;
   logic [15:0] next_sa;

   function automatic logic [15:0] apply_op(input logic [15:0] cur, input logic [15:0] wd,
                                            input logic [1:0] sel);
      unique case (sel)
         2'h0: apply_op = wd;
         2'h1: apply_op = cur & ~wd;
         2'h2: apply_op = cur | wd;
         2'h3: apply_op = cur ^ wd;
      endcase
   endfunction : apply_op

   assign req = '{addr: paddr, write: pwrite, wdata: pwdata, strb: pstrb};
   assign access = psel && penable;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   // Only a full word or an aligned half-word strobe is a legal size.
   assign size_ok = (req.strb == erxpo_pkg::STRB_WORD) || (req.strb == erxpo_pkg::STRB_HALF_LO)
                    || (req.strb == erxpo_pkg::STRB_HALF_HI);
   assign receive_enable_bit = control[erxpo_pkg::CTRL_RX_ENABLE_BIT];
   assign pattern_match_mode_select = control[erxpo_pkg::CTRL_MODE_LSB +: 4];
   assign match_ofs_locked = receive_enable_bit && (pattern_match_mode_select != 4'h0);

   // A high half-word strobe only touches reserved bits, so the offset and station address store nothing.
   always_comb begin
      next_match_ofs = apply_op(pattern_match_offset, req.wdata[15:0], req.addr[3:2]);
      next_sa = apply_op(station_addr, req.wdata[15:0], req.addr[3:2]);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pattern_match_offset <= erxpo_pkg::MATCH_OFS_RESET;
      end else if (access && req.write && size_ok && req.strb[0] && !match_ofs_locked
                   && req.addr[11:4] == erxpo_pkg::OFS_MATCH_OFS[11:4]) begin
         pattern_match_offset <= next_match_ofs;
      end
   end

   // The factory value is captured on the first clock after release, not by the reset itself.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sa_loaded <= 1'b0;
      end else begin
         sa_loaded <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!sa_loaded) begin
         station_addr <= factory_station_addr;
      end else if (access && req.write && size_ok && req.strb[0]
                   && req.addr[11:4] == erxpo_pkg::OFS_SA[11:4]) begin
         station_addr <= next_sa;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         control <= erxpo_pkg::CTRL_RESET;
      end else if (access && req.write && size_ok && req.addr == erxpo_pkg::OFS_CTRL) begin
         control <= {20'h0_0000, req.wdata[11:8], 7'h00, req.wdata[0]};
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            erxpo_pkg::OFS_MATCH_OFS: prdata <= {16'h0000, pattern_match_offset};
            erxpo_pkg::OFS_SA: prdata <= {16'h0000, station_addr};
            erxpo_pkg::OFS_CTRL: prdata <= control;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Offset goes to the receive matcher only; transmit uses the station address.
   assign rx_pattern_match_offset = pattern_match_offset;
   assign station_addr_octet_first = station_addr[7:0];
   assign station_addr_octet_second = station_addr[15:8];
endmodule : erxpo_regs
`default_nettype wire

//--- tb/erxpo_regs_assertions.sv
/* Port checker for erxpo_regs, bound to every instance of it.
 Assumes the block's clk and resetn and the package offsets. */
`timescale 1ns/1ns
`default_nettype none
module erxpo_chk (
   // Bus, clock and reset
   input wire logic clk, resetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [3:0] pstrb,
   // Station address and offset
   input wire logic [15:0] factory_station_addr, rx_pattern_match_offset,
   input wire logic [7:0] station_addr_octet_first, station_addr_octet_second
);
   wire logic acc = psel && penable;
   wire logic rd = acc && !pwrite;
   wire logic wr = acc && pwrite;
   wire logic [15:0] sa = {station_addr_octet_second, station_addr_octet_first};
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   chk_sa_load: assert property ($rose(resetn) |=> sa == $past(factory_station_addr))
      else $error("factory value not loaded");
   // The edge after release is skipped because that edge performs the factory load.
   chk_sa_hold: assert property (!wr && $past(resetn) |=> $stable(sa))
      else $error("station address moved without a write");
   chk_ofs_hold: assert property (!wr |=> $stable(rx_pattern_match_offset))
      else $error("offset moved without a write");
   chk_rd_upper: assert property (rd |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   chk_rd_sa: assert property (rd && paddr == erxpo_pkg::OFS_SA |-> prdata[15:0] == sa)
      else $error("station address read wrong");
   chk_rd_ofs: assert property (rd && paddr == erxpo_pkg::OFS_MATCH_OFS
      |-> prdata[15:0] == rx_pattern_match_offset) else $error("offset read wrong");
   chk_sa_write: assert property (wr && paddr == erxpo_pkg::OFS_SA && pstrb inside {4'hF, 4'h3}
      |=> sa == $past(pwdata[15:0])) else $error("station address write lost");
   chk_byte_drop: assert property (wr && !(pstrb inside {4'hF, 4'h3})
      |=> $stable(sa) && $stable(rx_pattern_match_offset)) else $error("byte write took effect");
   chk_bus_ok: assert property (acc |-> pready && !pslverr)
      else $error("bus answered with wait or error");
   cover property (wr && paddr == erxpo_pkg::OFS_MATCH_OFS_INV);
   cover property (rd && paddr == erxpo_pkg::OFS_SA);
   cover property (wr && pstrb == 4'h1);
endmodule : erxpo_chk
bind erxpo_regs erxpo_chk u_chk (.*);
`default_nettype wire

//--- tb/erxpo_regs_tb.sv
/* Bench for erxpo_regs with a register model in 16-bit vectors.
 Assumes zero-wait APB and the package offsets. */
`timescale 1ns/1ns
`default_nettype none
module erxpo_regs_tb;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, d, c;
   logic [3:0] pstrb, s;
   logic [15:0] f, po, m[2];
   logic [7:0] o1, o2;
   // Control settings, locked and unlocked.
   logic [31:0] ct[5] = '{32'h0, 32'h101, 32'h001, 32'h100, 32'hF01};
   logic [3:0] sx[4] = '{4'hF, 4'h3, 4'hC, 4'h1};
   int n_fail = 0, n_tests = 0, k;
   erxpo_regs DUT (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .factory_station_addr(f), .rx_pattern_match_offset(po),
      .station_addr_octet_first(o1), .station_addr_octet_second(o2));
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
      input logic [3:0] st);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, wd, st};
      @(posedge clk) penable <= 1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      {psel, penable} <= 2'b00;
      @(posedge clk);
   endtask : apb
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task automatic chk;
      apb(0, erxpo_pkg::OFS_MATCH_OFS, 0, 4'hF);
      cmp("offset", {16'h0, m[0]}, r);
      apb(0, erxpo_pkg::OFS_SA, 0, 4'hF);
      cmp("station address", {16'h0, m[1]}, r);
      cmp("ports", {m[1], m[0]}, {o2, o1, po});
      cmp("bus status", 32'h0000_0002, {30'h0000_0000, pready, pslverr});
      $display("test done, %0d compares", n_tests);
   endtask : chk
   task automatic results;
      $display("compares %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   initial begin
      {resetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      f = 16'($urandom(32'h4A30));
      for (int t = 0; t < 2; t++) begin
         repeat (2) @(posedge clk);
         resetn <= 1;
         repeat (2) @(posedge clk);
         m = '{16'h0, f};
         chk;
         for (int i = 0; i < 40 && t == 0; i++) begin
            k = i % 8;
            if (k == 0) begin
               c = ct[i / 8];
               apb(1, erxpo_pkg::OFS_CTRL, c, 4'hF);
            end
            d = {16'h0, 16'($urandom)};
            s = sx[$urandom % 4];
            apb(1, 12'(k * 4), d, s);
            if (s inside {4'hF, 4'h3} && !(k < 4 && c[0] && c[11:8] != 0))
               case (k % 4)
                  0: m[k / 4] = d[15:0];
                  1: m[k / 4] &= ~d[15:0];
                  2: m[k / 4] |= d[15:0];
                  default: m[k / 4] ^= d[15:0];
               endcase
            chk;
         end
         apb(0, 12'h0FC, 0, 4'hF);
         cmp("unmapped", 32'h0, r);
         f = ~f;
         resetn <= 0;
      end
      results;
   end
   initial begin
      #50000;
      n_fail++;
      results;
   end
endmodule : erxpo_regs_tb
`default_nettype wire
